/* File: hw/tsl_pkg.sv */
// ****************************************************************
// Shared constants of the temperature sensor serial slave.
// ****************************************************************
package tsl_pkg;

  // Fixed upper four bits of the seven-bit bus address.
  localparam logic [3:0] ADDR_HI = 4'h9;

  // Register pointer codes.
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_LOWER = 2'h2;
  localparam logic [1:0] PTR_UPPER = 2'h3;

  // Pointer byte: bits above this one must be zero.
  localparam int PTR_SEL_MSB = 1;

  // Reset values.
  localparam logic [15:0] UPPER_RESET = 16'h5000;
  localparam logic [15:0] LOWER_RESET = 16'h4b00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [1:0] PTR_RESET = 2'h0;

  // Limit registers keep their lowest four bits at zero.
  localparam logic [7:0] LIMIT_LO_KEEP = 8'hf0;

  // Resolution field of the configuration byte.
  localparam int CFG_RES_LSB = 5;
  localparam int CFG_RES_MSB = 6;

  // Comparison mask: bits below the nine-bit result at lowest resolution.
  localparam logic [15:0] CMP_DROP_BASE = 16'h007f;

  // Bit counter value of the last bit of a byte.
  localparam logic [2:0] LAST_BIT = 3'h7;

endpackage : tsl_pkg

/* File: hw/tsl_sync.sv */
`timescale 1ns/1ns
// ****************************************************************
// Two-flop synchroniser for the bus pins with edge and condition detect.
// ****************************************************************
module tsl_sync (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Raw bus pins.
  input wire logic scl_in,
  input wire logic sda_in,
  // Synchronised levels and events.
  output logic sda_s,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);
  import tsl_pkg::*;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
  } tsl_sync_t;

  tsl_sync_t st_reg;
  tsl_sync_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = {scl_in, sda_in};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_reg <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3};
    end else begin
      st_reg <= st_next;
    end
  end

  // Bit 1 is the clock line, bit 0 the data line; the first stage is never read here.
  assign sda_s = st_reg.s2[0];
  assign scl_rise = st_reg.s2[1] & ~st_reg.s3[1];
  assign scl_fall = ~st_reg.s2[1] & st_reg.s3[1];
  assign start_det = st_reg.s2[1] & st_reg.s3[1] & st_reg.s3[0] & ~st_reg.s2[0];
  assign stop_det = st_reg.s2[1] & st_reg.s3[1] & ~st_reg.s3[0] & st_reg.s2[0];

endmodule : tsl_sync

/* File: hw/tsl_limit_cmp.sv */
`timescale 1ns/1ns
// ****************************************************************
// Resolution-masked signed comparison of a temperature with both limits.
// ****************************************************************
module tsl_limit_cmp (
  // Operands.
  input wire logic [15:0] temp_value,
  input wire logic [15:0] upper_limit,
  input wire logic [15:0] lower_limit,
  input wire logic [1:0] resolution,
  // Results.
  output logic above_upper,
  output logic below_lower
);
  import tsl_pkg::*;

  logic [15:0] keep;

  always_comb begin
    // Nine bits kept at code 0, one more for each step up to twelve.
    keep = ~(CMP_DROP_BASE >> resolution);
    above_upper = $signed(temp_value & keep) > $signed(upper_limit & keep);
    below_lower = $signed(temp_value & keep) < $signed(lower_limit & keep);
  end

endmodule : tsl_limit_cmp

/* File: hw/tsl_slave.sv */
`timescale 1ns/1ns
// How it works
// - Upper limit 16-bit, resets to 80 degrees.
// - Upper limit low four bits read zero.
// - Bit 15 sign, bit 14 magnitude MSB.
// - Upper compare uses only resolution top bits.
// - Lower limit 16-bit, resets to 75 degrees.
// - Lower limit low four bits fixed zero.
// - Lower compare uses only resolution top bits.
// - Nine clocks per byte, MSB first, ack.
// - SDA changes only while SCL low.
// - Device acknowledges matching address, valid pointer and every data byte low.
// - Address is 1001 plus three select pins.
// - Match compared, ack after read/write bit.
// - Write bit zero, then acknowledged pointer byte.
// - Nonzero upper pointer bits: no ack, abandon.
// - Pointer kept between transfers.
// - Read data starts after ack; 1 or 2 bytes.
// - Repeated start reads; plain bytes write register.
// - Stuck low read ignores start and stop.
// - Two pointer bits select the register.
// - Readable temperature frozen during a read.
module tsl_slave (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Two-wire bus.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address select straps.
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  // Converter side.
  input wire logic [15:0] temp_value,
  input wire logic temp_load,
  // Register contents for the alarm logic.
  output logic [15:0] temp_readable,
  output logic [7:0] cfg_value,
  output logic [15:0] upper_trip_limit,
  output logic [15:0] lower_trip_limit,
  output logic [tsl_pkg::PTR_SEL_MSB:0] pointer_value,
  // Comparison results.
  output logic over_upper,
  output logic under_lower
);
  import tsl_pkg::*;

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_AACK = 9'h004,
    ST_PTR = 9'h008,
    ST_PACK = 9'h010,
    ST_WDATA = 9'h020,
    ST_WACK = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK = 9'h100
  } tsl_state_t;

  typedef struct packed {
    tsl_state_t state;
    logic [2:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic rw;
    logic byte_idx;
    logic mack;
    logic mack_seen;
    logic [7:0] hi_byte;
    logic [1:0] pointer;
    logic [7:0] cfg;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] temp;
    logic drive_level;
    logic oe;
    logic over_upper;
    logic under_lower;
    logic [2:0] a_s1;
    logic [2:0] a_s2;
  } tsl_slave_t;

  tsl_slave_t st_reg;
  tsl_slave_t st_next;

  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic above_upper;
  logic below_lower;
  logic [7:0] rx_byte;
  logic rd_busy;
  logic stuck_low;
  logic [15:0] sel_reg;

  // ****************************************************************
  // Pin synchroniser and limit comparison.
  // ****************************************************************
  tsl_sync u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  tsl_limit_cmp u_cmp (
    .temp_value(temp_value),
    .upper_limit(st_reg.upper),
    .lower_limit(st_reg.lower),
    .resolution(st_reg.cfg[CFG_RES_MSB:CFG_RES_LSB]),
    .above_upper(above_upper),
    .below_lower(below_lower)
  );

  // ****************************************************************
  // Byte engine.
  // ****************************************************************
  always_comb begin
    rx_byte = {st_reg.shift[6:0], sda_s};
    rd_busy = (st_reg.state == ST_RDATA) || (st_reg.state == ST_RACK);
    // A read cut short while a zero is on the line hangs until released.
    stuck_low = (st_reg.state == ST_RDATA) && st_reg.oe;
    case (st_reg.pointer)
      PTR_TEMP: sel_reg = st_reg.temp;
      PTR_CFG: sel_reg = {st_reg.cfg, 8'h00};
      PTR_LOWER: sel_reg = st_reg.lower;
      default: sel_reg = st_reg.upper;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.a_s1 = {addr_select_bit2, addr_select_bit1, addr_select_bit0};
    st_next.a_s2 = st_reg.a_s1;
    st_next.over_upper = above_upper;
    st_next.under_lower = below_lower;
    // Fresh conversions are held off while a read is under way.
    if (temp_load && !rd_busy) begin
      st_next.temp = temp_value;
    end
    if (start_det && !stuck_low) begin
      st_next.state = ST_ADDR;
      st_next.bitcnt = 3'h0;
      st_next.oe = 1'b0;
    end else if (stop_det && !stuck_low) begin
      st_next.state = ST_IDLE;
      st_next.oe = 1'b0;
    end else begin
      case (st_reg.state)
        ST_IDLE: begin
          st_next.oe = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            st_next.shift = rx_byte;
            st_next.bitcnt = st_reg.bitcnt + 3'h1;
            if (st_reg.bitcnt == LAST_BIT) begin
              st_next.rw = rx_byte[0];
              if (rx_byte[7:1] == {ADDR_HI, st_reg.a_s2}) begin
                st_next.state = ST_AACK;
              end else begin
                st_next.state = ST_IDLE;
              end
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (!st_reg.oe) begin
              st_next.oe = 1'b1;
            end else if (st_reg.rw) begin
              // The first data bit goes out on the fall ending the ack clock.
              st_next.state = ST_RDATA;
              st_next.byte_idx = 1'b0;
              st_next.bitcnt = 3'h0;
              st_next.tx = sel_reg[15:8];
              st_next.oe = ~sel_reg[15];
            end else begin
              st_next.state = ST_PTR;
              st_next.bitcnt = 3'h0;
              st_next.oe = 1'b0;
            end
          end
        end
        ST_PTR: begin
          if (scl_rise) begin
            st_next.shift = rx_byte;
            st_next.bitcnt = st_reg.bitcnt + 3'h1;
            if (st_reg.bitcnt == LAST_BIT) begin
              if (rx_byte[7:PTR_SEL_MSB + 1] != 6'h00) begin
                st_next.state = ST_IDLE;
              end else begin
                st_next.pointer = rx_byte[PTR_SEL_MSB:0];
                st_next.state = ST_PACK;
              end
            end
          end
        end
        ST_PACK, ST_WACK: begin
          if (scl_fall) begin
            if (!st_reg.oe) begin
              st_next.oe = 1'b1;
            end else begin
              st_next.oe = 1'b0;
              st_next.state = ST_WDATA;
              st_next.bitcnt = 3'h0;
              st_next.byte_idx = (st_reg.state == ST_WACK);
            end
          end
        end
        ST_WDATA: begin
          if (scl_rise) begin
            st_next.shift = rx_byte;
            st_next.bitcnt = st_reg.bitcnt + 3'h1;
            if (st_reg.bitcnt == LAST_BIT) begin
              st_next.state = ST_WACK;
              if (st_reg.pointer == PTR_CFG) begin
                st_next.cfg = rx_byte;
              end else if (!st_reg.byte_idx) begin
                st_next.hi_byte = rx_byte;
              end else if (st_reg.pointer == PTR_UPPER) begin
                st_next.upper = {st_reg.hi_byte, rx_byte & LIMIT_LO_KEEP};
              end else if (st_reg.pointer == PTR_LOWER) begin
                st_next.lower = {st_reg.hi_byte, rx_byte & LIMIT_LO_KEEP};
              end
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            st_next.tx = {st_reg.tx[6:0], 1'b0};
            st_next.bitcnt = st_reg.bitcnt + 3'h1;
            if (st_reg.bitcnt == LAST_BIT) begin
              st_next.state = ST_RACK;
              st_next.mack_seen = 1'b0;
            end
          end else if (scl_fall) begin
            st_next.oe = ~st_reg.tx[7];
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            st_next.mack = ~sda_s;
            st_next.mack_seen = 1'b1;
          end else if (scl_fall) begin
            if (!st_reg.mack_seen) begin
              st_next.oe = 1'b0;
            end else if (st_reg.mack && !st_reg.byte_idx && st_reg.pointer != PTR_CFG) begin
              st_next.state = ST_RDATA;
              st_next.byte_idx = 1'b1;
              st_next.bitcnt = 3'h0;
              st_next.tx = sel_reg[7:0];
              st_next.oe = ~sel_reg[7];
            end else begin
              st_next.state = ST_IDLE;
              st_next.oe = 1'b0;
            end
          end
        end
        default: begin
          st_next.state = ST_IDLE;
          st_next.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.pointer <= PTR_RESET;
      st_reg.cfg <= CFG_RESET;
      st_reg.upper <= UPPER_RESET;
      st_reg.lower <= LOWER_RESET;
      st_reg.temp <= TEMP_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign sda_out = st_reg.drive_level;
  assign sda_oe = st_reg.oe;
  assign temp_readable = st_reg.temp;
  assign cfg_value = st_reg.cfg;
  assign upper_trip_limit = st_reg.upper;
  assign lower_trip_limit = st_reg.lower;
  assign pointer_value = st_reg.pointer;
  assign over_upper = st_reg.over_upper;
  assign under_lower = st_reg.under_lower;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_upper_low_zero: assert property (st_reg.upper[3:0] == 4'h0)
    else $error("upper limit low nibble not zero");

  a_lower_low_zero: assert property (st_reg.lower[3:0] == 4'h0)
    else $error("lower limit low nibble not zero");

  a_upper_mask_nine: assert property ((st_reg.cfg[6:5] == 2'h0)
      && (temp_value[15:7] == st_reg.upper[15:7]) |=> !over_upper)
    else $error("upper compare used bits below resolution");

  a_lower_mask_nine: assert property ((st_reg.cfg[6:5] == 2'h0)
      && (temp_value[15:7] == st_reg.lower[15:7]) |=> !under_lower)
    else $error("lower compare used bits below resolution");

  a_addr_ack_drive: assert property ((st_reg.state == ST_ADDR) && scl_rise
      && (st_reg.bitcnt == 3'h7) && (rx_byte[7:1] == {4'h9, st_reg.a_s2})
      |=> (st_reg.state == ST_AACK) && !sda_oe)
    else $error("address match not followed by ack phase");

  a_write_ack: assert property ((st_reg.state == ST_WACK) && scl_fall && !sda_oe
      && !start_det && !stop_det |=> sda_oe ##1 (sda_out == 1'b0))
    else $error("received byte not acknowledged");

  a_bad_ptr_nack: assert property ((st_reg.state == ST_PTR) && scl_rise
      && (st_reg.bitcnt == 3'h7) && (rx_byte[7:2] != 6'h00) && !start_det && !stop_det
      |=> (st_reg.state == ST_IDLE) [*2] and !sda_oe [*2])
    else $error("bad pointer byte was acknowledged");

  a_pointer_kept: assert property ($changed(pointer_value) |->
      $past(st_reg.state) == ST_PTR)
    else $error("pointer changed outside pointer phase");

  a_stuck_hold: assert property (stuck_low && (start_det || stop_det)
      |=> st_reg.state == ST_RDATA)
    else $error("start or stop honoured while holding data low");

  a_temp_frozen: assert property (rd_busy && temp_load |=> $stable(temp_readable))
    else $error("readable temperature changed during a read");

  a_idle_release: assert property ((st_reg.state == ST_IDLE) |-> !sda_oe)
    else $error("data line driven while idle");

  c_two_byte_read: cover property ((st_reg.state == ST_RACK) && st_reg.byte_idx);
  c_pointer_set: cover property ((st_reg.state == ST_PACK) && sda_oe);
  c_limit_write: cover property ($changed(upper_trip_limit));
  c_stuck_read: cover property (stuck_low && stop_det);

endmodule : tsl_slave

/* File: test/tsl_master_model.sv */
`timescale 1ns/1ns
// ****************************************************************
// Bus master model: makes the bus clock and pulls the data line low.
// ****************************************************************
module tsl_master_model (
  // Bus wires, data as a release flag since the line is open drain.
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // The clock stands high between frames; data moves only while it is low.
  task automatic bit_x(input logic b, output logic r);
    scl = 1'b0;
    #100 sda_rel = b;
    #400 scl = 1'b1;
    #150 r = sda;
    #150;
  endtask : bit_x

  task automatic byte_x(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
      output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(ack_in, ack_out);
  endtask : byte_x

  task automatic start_c();
    scl = 1'b0;
    #300 sda_rel = 1'b1;
    #200 scl = 1'b1;
    #200 sda_rel = 1'b0;
    #200;
  endtask : start_c

  task automatic stop_c();
    scl = 1'b0;
    #300 sda_rel = 1'b0;
    #200 scl = 1'b1;
    #200 sda_rel = 1'b1;
    #400;
  endtask : stop_c
endmodule : tsl_master_model

/* File: test/tsl_slave_tb.sv */
`timescale 1ns/1ns
module tsl_slave_tb;
  import tsl_pkg::*;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [7:0] ADDR_W = {ADDR_HI, STRAP, 1'b0};
  localparam int LIMIT = 20000;
  logic sys_clk, resetn, scl, sda_rel, sda, sda_out, sda_oe, temp_load, over_upper, under_lower;
  logic [15:0] temp_value, temp_readable, upper_trip_limit, lower_trip_limit, rd;
  logic [7:0] cfg_value, rx;
  logic [1:0] pointer_value;
  logic ak;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  // The device can only pull the pulled-up line low.
  assign sda = sda_rel & ~(sda_oe & ~sda_out);

  tsl_master_model u_m (.scl(scl), .sda_rel(sda_rel), .sda(sda));
  tsl_slave u_dut (.sys_clk(sys_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_bit0(STRAP[0]),
    .addr_select_bit1(STRAP[1]), .addr_select_bit2(STRAP[2]), .temp_value(temp_value),
    .temp_load(temp_load), .temp_readable(temp_readable), .cfg_value(cfg_value),
    .upper_trip_limit(upper_trip_limit), .lower_trip_limit(lower_trip_limit),
    .pointer_value(pointer_value), .over_upper(over_upper), .under_lower(under_lower));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      $display("[FAIL] %0t run took too long", $time);
      summarize();
    end
  end

  always @(sda_oe) begin
    if (resetn === 1'b1) check({15'h0, scl}, 16'h0, "data moved while clock high");
  end

  // ****************************************************************
  // Checking and bus tasks.
  // ****************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic wr_reg(input logic [7:0] ptr, input logic [15:0] d, input int n,
      input logic ok);
    logic [7:0] r;
    logic a;
    u_m.start_c();
    u_m.byte_x(ADDR_W, 1'b1, r, a);
    check({15'h0, a}, 16'h0, "address not acknowledged");
    u_m.byte_x(ptr, 1'b1, r, a);
    check({15'h0, a}, {15'h0, ~ok}, "pointer acknowledge wrong");
    for (int i = n - 1; i >= 0; i--) begin
      u_m.byte_x(d[i*8 +: 8], 1'b1, r, a);
      check({15'h0, a}, 16'h0, "data not acknowledged");
    end
    u_m.stop_c();
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] ptr, input int n, input logic set_ptr,
      output logic [15:0] d);
    logic [7:0] r;
    logic a;
    d = 16'h0;
    if (set_ptr) begin
      u_m.start_c();
      u_m.byte_x(ADDR_W, 1'b1, r, a);
      u_m.byte_x(ptr, 1'b1, r, a);
    end
    u_m.start_c();
    u_m.byte_x(ADDR_W | 8'h01, 1'b1, r, a);
    check({15'h0, a}, 16'h0, "read address not acknowledged");
    for (int i = n - 1; i >= 0; i--) begin
      u_m.byte_x(8'hff, i == 0, r, a);
      d[i*8 +: 8] = r;
    end
    u_m.stop_c();
  endtask : rd_reg

  task automatic load_temp(input logic [15:0] v);
    @(posedge sys_clk) #1 temp_value = v;
    temp_load = 1'b1;
    @(posedge sys_clk) #1 temp_load = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : load_temp

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    resetn = 1'b0;
    temp_value = 16'h0;
    temp_load = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check(upper_trip_limit, 16'h5000, "upper reset");
    check(lower_trip_limit, 16'h4b00, "lower reset");
    check({14'h0, pointer_value}, 16'h0, "pointer reset");
    $display("test reset done");
    u_m.start_c();
    u_m.byte_x({ADDR_HI, ~STRAP, 1'b0}, 1'b1, rx, ak);
    check({15'h0, ak}, 16'h1, "foreign address acknowledged");
    u_m.stop_c();
    $display("test address done");
    wr_reg(8'h03, 16'h123f, 2, 1'b1);
    check(upper_trip_limit, 16'h1230, "upper write");
    wr_reg(8'h02, 16'hffff, 2, 1'b1);
    check(lower_trip_limit, 16'hfff0, "lower write");
    wr_reg(8'h43, 16'h0, 0, 1'b0);
    check({14'h0, pointer_value}, 16'h2, "bad pointer taken");
    $display("test write done");
    rd_reg(8'h03, 2, 1'b1, rd);
    check(rd, 16'h1230, "upper read");
    check({14'h0, pointer_value}, 16'h3, "pointer value");
    rd_reg(8'h00, 2, 1'b0, rd);
    check(rd, 16'h1230, "read with kept pointer");
    rd_reg(8'h02, 2, 1'b1, rd);
    check(rd, 16'hfff0, "lower read");
    wr_reg(8'h01, 16'h0060, 1, 1'b1);
    rd_reg(8'h01, 1, 1'b1, rd);
    check(rd, 16'h0060, "config read");
    check({8'h0, cfg_value}, 16'h0060, "config value");
    $display("test read done");
    for (int k = 0; k < 4; k++) begin
      wr_reg(8'h01, 16'(k << 5), 1, 1'b1);
      load_temp(16'h1270);
      check({15'h0, over_upper}, 16'(k != 0), "upper compare");
      load_temp(16'hffe0);
      check({15'h0, under_lower}, 16'(k == 3), "lower compare");
    end
    $display("test compare done");
    load_temp(16'h1900);
    check(temp_readable, 16'h1900, "temperature load");
    wr_reg(8'h00, 16'h5550, 2, 1'b1);
    check(temp_readable, 16'h1900, "read-only temperature written");
    fork
      rd_reg(8'h00, 2, 1'b0, rd);
      begin
        #10000;
        load_temp(16'h2000);
      end
    join
    check(rd, 16'h1900, "temperature read");
    check(temp_readable, 16'h1900, "load during read taken");
    $display("test freeze done");
    wr_reg(8'h03, 16'h0, 0, 1'b1);
    u_m.start_c();
    u_m.byte_x(ADDR_W | 8'h01, 1'b1, rx, ak);
    u_m.byte_x(8'hff, 1'b0, rx, ak);
    check({8'h0, rx}, 16'h0012, "first byte");
    u_m.stop_c();
    check({15'h0, sda_oe}, 16'h1, "stop not ignored");
    check({15'h0, sda_out}, 16'h0, "data line driven high");
    repeat (8) u_m.bit_x(1'b1, ak);
    u_m.stop_c();
    check({15'h0, sda_oe}, 16'h0, "line still held");
    rd_reg(8'h00, 2, 1'b0, rd);
    check(rd, 16'h1230, "read after recovery");
    $display("test stuck done");
    summarize();
  end
endmodule : tsl_slave_tb
